// file: verilog/clock_generator_mode_control.sv
// Clock generator mode control: APB registers, scheme decode, loss events and interrupt
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
module clock_generator_mode_control #(
	parameter int INT_REF_KHZ = 243,
	parameter int EXT_REF_KHZ = 32,
	parameter int LOSS_TIMEOUT = clock_gen_pkg::CLOCK_LOSS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [clock_gen_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ref_clock_pin,
	input wire logic loop_locked_pin,
	input wire logic osc_stable_pin,
	output logic irq,
	output logic system_reset_request,
	output logic oscillator_request,
	output logic high_gain_select,
	output logic range_high,
	output logic oscillator_stop_enable,
	output clock_gen_pkg::scheme_t clock_scheme_select,
	output logic [7:0] trim_value,
	output logic [31:0] output_freq_khz,
	output logic [31:0] bus_freq_khz
);
	import clock_gen_pkg::*;

	// ********************************
	// Declarations
	// ********************************
	logic [7:0] scheme_ctrl_reg;
	logic [7:0] factor_ctrl_reg;
	logic [7:0] trim_reg;
	logic [7:0] mask_reg;
	logic [7:0] flags_reg;
	logic [31:0] rdata_next;
	logic slverr_next;
	logic mapped;
	logic setup;
	logic wr_access;
	logic lock_sync1_reg;
	logic lock_sync2_reg;
	logic lock_last_reg;
	logic stable_sync1_reg;
	logic stable_sync2_reg;
	logic loop_engaged;
	logic ext_ref_used;
	logic lock_loss_event;
	logic clock_loss_event;
	logic lock_reset_en;
	logic clock_reset_en;
	logic flag_clear_wr;
	logic [7:0] status_first;
	logic [7:0] status_second;
	logic [6:0] prescale;
	logic [4:0] factor;
	logic [31:0] freq_khz;
	scheme_t scheme;

	// ********************************
	// APB slave
	// ********************************
	// Read data is latched in the setup cycle, so every access completes with no wait state
	assign pready = 1'b1;
	assign setup = psel && !penable;
	assign wr_access = psel && penable && pready && pwrite;

	// Address decode; anything else answers with an error
	always_comb begin
		mapped = 1'b1;
		rdata_next = 32'h0000_0000;
		if (paddr == SCHEME_CTRL_ADDR) begin
			rdata_next = {24'h00_0000, scheme_ctrl_reg & SCHEME_CTRL_WMASK};
		end else if (paddr == FACTOR_CTRL_ADDR) begin
			rdata_next = {24'h00_0000, factor_ctrl_reg};
		end else if (paddr == STATUS_FIRST_ADDR) begin
			rdata_next = {24'h00_0000, status_first};
		end else if (paddr == STATUS_SECOND_ADDR) begin
			rdata_next = {24'h00_0000, status_second};
		end else if (paddr == TRIM_ADDR) begin
			rdata_next = {24'h00_0000, trim_reg};
		end else if (paddr == IRQ_MASK_ADDR) begin
			rdata_next = {24'h00_0000, mask_reg};
		end else begin
			mapped = 1'b0;
		end
		slverr_next = !mapped;
	end

	// Latch the answer at the setup edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0000_0000 : rdata_next;
			pslverr <= slverr_next;
		end
	end

	// ********************************
	// Control registers
	// ********************************
	// Writes land only at the access edge; bit 0 of scheme control is never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scheme_ctrl_reg <= SCHEME_CTRL_RST;
			factor_ctrl_reg <= FACTOR_CTRL_RST;
			trim_reg <= TRIM_RST;
			mask_reg <= IRQ_MASK_RST;
		end else if (wr_access) begin
			if (paddr == SCHEME_CTRL_ADDR) begin
				scheme_ctrl_reg <= pwdata[7:0] & SCHEME_CTRL_WMASK;
			end else if (paddr == FACTOR_CTRL_ADDR) begin
				factor_ctrl_reg <= pwdata[7:0];
			end else if (paddr == TRIM_ADDR) begin
				trim_reg <= pwdata[7:0];
			end else if (paddr == IRQ_MASK_ADDR) begin
				mask_reg <= pwdata[7:0] & FLAG_MASK;
			end
		end
	end

	// Field extraction
	assign scheme = scheme_t'(scheme_ctrl_reg[SCHEME_LSB +: 2]);
	assign lock_reset_en = factor_ctrl_reg[LOCK_RESET_EN_BIT];
	assign clock_reset_en = factor_ctrl_reg[CLOCK_RESET_EN_BIT];
	assign loop_engaged = (scheme == SCHEME_INT) || (scheme == SCHEME_EXT);
	assign ext_ref_used = (scheme == SCHEME_EXT) || (scheme == SCHEME_BYP);

	// Oscillator controls; the request is masked when the internal reference drives the loop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oscillator_request <= 1'b0;
			high_gain_select <= 1'b0;
			range_high <= 1'b0;
			oscillator_stop_enable <= 1'b0;
			clock_scheme_select <= SCHEME_SELF;
			trim_value <= TRIM_RST;
		end else begin
			oscillator_request <= scheme_ctrl_reg[REF_SEL_BIT] && scheme != SCHEME_INT;
			high_gain_select <= scheme_ctrl_reg[HIGH_GAIN_BIT];
			range_high <= scheme_ctrl_reg[RANGE_BIT];
			oscillator_stop_enable <= scheme_ctrl_reg[STOP_EN_BIT];
			clock_scheme_select <= scheme;
			trim_value <= trim_reg;
		end
	end

	// ********************************
	// Frequency decode
	// ********************************
	scheme_freq_decode #(
		.INT_REF_KHZ(INT_REF_KHZ),
		.EXT_REF_KHZ(EXT_REF_KHZ)
	) u_decode (
		.scheme(scheme),
		.range_high(scheme_ctrl_reg[RANGE_BIT]),
		.factor_code(factor_ctrl_reg[FACTOR_LSB +: 3]),
		.divider_code(factor_ctrl_reg[DIVIDER_LSB +: 3]),
		.prescale(prescale),
		.factor(factor),
		.freq_khz(freq_khz)
	);

	// Registered frequency report; the bus runs at half the generator output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_freq_khz <= 32'(SELF_CLOCKED_KHZ);
			bus_freq_khz <= 32'(SELF_CLOCKED_KHZ / 2);
		end else begin
			output_freq_khz <= freq_khz;
			bus_freq_khz <= freq_khz >> 1;
		end
	end

	// ********************************
	// Loss detection
	// ********************************
	// Lock and stable indications come from the analog side and are synchronised first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_sync1_reg <= 1'b0;
			lock_sync2_reg <= 1'b0;
			lock_last_reg <= 1'b0;
			stable_sync1_reg <= 1'b0;
			stable_sync2_reg <= 1'b0;
		end else begin
			lock_sync1_reg <= loop_locked_pin;
			lock_sync2_reg <= lock_sync1_reg;
			lock_last_reg <= lock_sync2_reg;
			stable_sync1_reg <= osc_stable_pin;
			stable_sync2_reg <= stable_sync1_reg;
		end
	end

	// Lock loss only means something while the loop is engaged
	assign lock_loss_event = loop_engaged && lock_last_reg && !lock_sync2_reg;

	clock_loss_monitor #(
		.TIMEOUT(LOSS_TIMEOUT)
	) u_loss (
		.pclk(pclk),
		.presetn(presetn),
		.ref_pin(ref_clock_pin),
		.enable(ext_ref_used && !scheme_ctrl_reg[LOSS_DETECT_DIS_BIT]),
		.loss_pulse(clock_loss_event)
	);

	// ********************************
	// Status, interrupt and reset request
	// ********************************
	assign flag_clear_wr = wr_access && paddr == STATUS_FIRST_ADDR;

	// Sticky flags cleared by writing one; a new event in the clear cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg <= 8'h00;
		end else begin
			flags_reg <= (flags_reg & ~(flag_clear_wr ? pwdata[7:0] & FLAG_MASK : 8'h00))
				| ({7'h00, lock_loss_event && !lock_reset_en} << ST_LOCK_LOSS_BIT)
				| ({7'h00, clock_loss_event && !clock_reset_en} << ST_CLOCK_LOSS_BIT);
		end
	end

	// A loss with its reset enable set asks for a system reset and leaves the flags alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_reset_request <= 1'b0;
		end else begin
			system_reset_request <= (lock_loss_event && lock_reset_en) || (clock_loss_event && clock_reset_en);
		end
	end

	assign irq = |(flags_reg & mask_reg);
	assign status_first = flags_reg | ({7'h00, irq} << ST_IRQ_BIT) | ({7'h00, lock_sync2_reg} << ST_LOCKED_BIT);
	assign status_second = {7'h00, stable_sync2_reg} << ST_STABLE_BIT;

	// ********************************
	// Checks
	// ********************************
	unimpl_bit_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && paddr == SCHEME_CTRL_ADDR |=> !prdata[0]) else $error("bit 0 read nonzero");

	internal_ignores_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
		scheme == SCHEME_INT |=> !oscillator_request) else $error("oscillator requested in internal scheme");

	lock_loss_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		lock_loss_event && !lock_reset_en |=> flags_reg[ST_LOCK_LOSS_BIT] && !system_reset_request) else $error("lock loss not flagged");

	clock_loss_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		clock_loss_event && !clock_reset_en |=> flags_reg[ST_CLOCK_LOSS_BIT]) else $error("clock loss not flagged");

	loss_reset_req_a: assert property (@(posedge pclk) disable iff (!presetn)
		system_reset_request |-> $past(lock_loss_event && lock_reset_en) || $past(clock_loss_event && clock_reset_en))
		else $error("reset request without enabled loss");

	flag_sticky_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		flags_reg[ST_LOCK_LOSS_BIT] && !flag_clear_wr |=> flags_reg[ST_LOCK_LOSS_BIT]) else $error("flag lost without clear");

	// Checked only once the controls have stood a cycle, since the report lags a write by one edge
	fee_freq_match_a: assert property (@(posedge pclk) disable iff (!presetn)
		scheme == SCHEME_EXT && $stable(factor_ctrl_reg) && $stable(scheme_ctrl_reg) |->
		output_freq_khz == 32'((64'(EXT_REF_KHZ)
		* 64'(scheme_ctrl_reg[RANGE_BIT] ? HIGH_RANGE_PRESCALE : LOW_RANGE_PRESCALE)
		* 64'(FACTOR_BASE + FACTOR_STEP * int'(factor_ctrl_reg[FACTOR_LSB +: 3])))
		>> factor_ctrl_reg[DIVIDER_LSB +: 3]))
		else $error("engaged external frequency wrong");

	bus_half_out_a: assert property (@(posedge pclk) disable iff (!presetn)
		##1 bus_freq_khz == (output_freq_khz >> 1)) else $error("bus clock not half of output");

	factor_ten_a: assert property (@(posedge pclk) disable iff (!presetn)
		factor_ctrl_reg[6:4] == 3'b011 |-> factor == 5'd10) else $error("factor code 011 not ten");

	// Prescale seen by the decoder follows the stored range bit, not the registered pin copy
	range_prescale_a: assert property (@(posedge pclk) disable iff (!presetn)
		prescale == (scheme_ctrl_reg[RANGE_BIT] ? 7'h01 : 7'h40)) else $error("prescale wrong for range");

	// A write of one clears the lock loss flag unless a new loss lands in the same cycle
	flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		flag_clear_wr && pwdata[ST_LOCK_LOSS_BIT] && !lock_loss_event |=> !flags_reg[ST_LOCK_LOSS_BIT])
		else $error("lock loss flag not cleared");

endmodule

// file: verilog/clock_gen_pkg.sv
// Package of offsets, fields, reset values and timing for the clock generator control block
package clock_gen_pkg;

	// ********************************
	// Register byte offsets on APB
	// ********************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] SCHEME_CTRL_ADDR = 8'h00;
	localparam logic [7:0] FACTOR_CTRL_ADDR = 8'h04;
	localparam logic [7:0] STATUS_FIRST_ADDR = 8'h08;
	localparam logic [7:0] STATUS_SECOND_ADDR = 8'h0C;
	localparam logic [7:0] TRIM_ADDR = 8'h10;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h14;

	// ********************************
	// Field positions
	// ********************************
	localparam int HIGH_GAIN_BIT = 7;
	localparam int RANGE_BIT = 6;
	localparam int REF_SEL_BIT = 5;
	localparam int SCHEME_LSB = 3;
	localparam int STOP_EN_BIT = 2;
	localparam int LOSS_DETECT_DIS_BIT = 1;
	localparam int LOCK_RESET_EN_BIT = 7;
	localparam int FACTOR_LSB = 4;
	localparam int CLOCK_RESET_EN_BIT = 3;
	localparam int DIVIDER_LSB = 0;
	localparam int ST_IRQ_BIT = 0;
	localparam int ST_CLOCK_LOSS_BIT = 1;
	localparam int ST_LOCK_LOSS_BIT = 2;
	localparam int ST_LOCKED_BIT = 3;
	localparam int ST_STABLE_BIT = 0;

	// ********************************
	// Reset values and masks
	// ********************************
	localparam logic [7:0] SCHEME_CTRL_RST = 8'h00;
	localparam logic [7:0] FACTOR_CTRL_RST = 8'h00;
	localparam logic [7:0] TRIM_RST = 8'h80;
	localparam logic [7:0] IRQ_MASK_RST = 8'h00;
	localparam logic [7:0] SCHEME_CTRL_WMASK = 8'hFE;
	localparam logic [7:0] FLAG_MASK = 8'h06;

	// ********************************
	// Clock schemes and frequency figures
	// ********************************
	typedef enum logic [1:0] {
		SCHEME_SELF = 2'b00,
		SCHEME_INT = 2'b01,
		SCHEME_EXT = 2'b11,
		SCHEME_BYP = 2'b10
	} scheme_t;
	localparam int SELF_CLOCKED_KHZ = 8000;
	localparam int INT_REF_DIV = 7;
	localparam logic [6:0] LOW_RANGE_PRESCALE = 7'd64;
	localparam logic [6:0] HIGH_RANGE_PRESCALE = 7'd1;
	localparam int FACTOR_BASE = 4;
	localparam int FACTOR_STEP = 2;
	localparam int FREQ_W = 32;

	// ********************************
	// Timing
	// ********************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int CLOCK_LOSS_NS = 2000;
	localparam int CLOCK_LOSS_CYCLES = (CLOCK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Loop multiplication factor from its three-bit code
	function automatic logic [4:0] factor_of(input logic [2:0] code);
		return 5'(FACTOR_BASE + FACTOR_STEP * int'(code));
	endfunction

endpackage

// file: verilog/scheme_freq_decode.sv
// Decoder of scheme, range, factor and divider codes into a generator frequency
`timescale 1ns/1ps
module scheme_freq_decode #(
	parameter int INT_REF_KHZ = 243,
	parameter int EXT_REF_KHZ = 32
) (
	input wire clock_gen_pkg::scheme_t scheme,
	input wire logic range_high,
	input wire logic [2:0] factor_code,
	input wire logic [2:0] divider_code,
	output logic [6:0] prescale,
	output logic [4:0] factor,
	output logic [31:0] freq_khz
);
	import clock_gen_pkg::*;

	logic [63:0] base_khz;

	// Prescale by range and factor decode
	assign prescale = range_high ? HIGH_RANGE_PRESCALE : LOW_RANGE_PRESCALE;
	assign factor = factor_of(factor_code);

	// Undivided frequency per scheme; multiply before the divide by seven to keep precision
	always_comb begin
		case (scheme)
			SCHEME_SELF: base_khz = 64'(SELF_CLOCKED_KHZ);
			SCHEME_BYP: base_khz = 64'(EXT_REF_KHZ);
			SCHEME_INT: base_khz = 64'(INT_REF_KHZ) * 64'(LOW_RANGE_PRESCALE) * 64'(factor) / 64'(INT_REF_DIV);
			default: base_khz = 64'(EXT_REF_KHZ) * 64'(prescale) * 64'(factor);
		endcase
	end

	// Divider codes are powers of two, so the divide is a shift
	assign freq_khz = 32'(base_khz >> divider_code);

endmodule

// file: verilog/clock_loss_monitor.sv
// Watchdog that flags a reference clock with no edges for too long
`timescale 1ns/1ps
module clock_loss_monitor #(
	parameter int TIMEOUT = clock_gen_pkg::CLOCK_LOSS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ref_pin,
	input wire logic enable,
	output logic loss_pulse
);
	import clock_gen_pkg::*;

	logic sync1_reg;
	logic sync2_reg;
	logic last_reg;
	logic [15:0] count_reg;
	logic lost_reg;
	logic edge_seen;

	// Two-stage synchroniser; only the second stage feeds the edge detector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			sync1_reg <= ref_pin;
			sync2_reg <= sync1_reg;
			last_reg <= sync2_reg;
		end
	end

	assign edge_seen = sync2_reg ^ last_reg;

	// Count quiet cycles; fire once per loss so a dead clock does not flood events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= 16'h0000;
			lost_reg <= 1'b0;
			loss_pulse <= 1'b0;
		end else begin
			loss_pulse <= 1'b0;
			if (!enable || edge_seen) begin
				count_reg <= 16'h0000;
				lost_reg <= 1'b0;
			end else if (!lost_reg && count_reg == 16'(TIMEOUT - 1)) begin
				lost_reg <= 1'b1;
				loss_pulse <= 1'b1;
			end else if (!lost_reg) begin
				count_reg <= count_reg + 16'h0001;
			end
		end
	end

	loss_after_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		loss_pulse |-> $past(enable) && $past(count_reg) == 16'(TIMEOUT - 1)) else $error("loss before timeout");

endmodule

// file: verif/ext_clock_source.sv
// Behavioural crystal, lock and stability source on the far side of the clock generator
`timescale 1ns/1ps
module ext_clock_source (
	input wire logic pclk,
	input wire logic run,
	input wire logic lock_level,
	input wire logic stable_level,
	output logic ref_clock_pin,
	output logic loop_locked_pin,
	output logic osc_stable_pin
);
	logic phase_reg;

	// ****************************************
	// Reference clock
	// ****************************************
	// Toggles every second pclk cycle; when stopped the line stands still, like a dead crystal
	initial begin
		phase_reg = 1'b0;
		ref_clock_pin = 1'b0;
	end
	always @(posedge pclk) begin
		if (run) begin
			phase_reg <= ~phase_reg;
			if (phase_reg) begin
				ref_clock_pin <= ~ref_clock_pin;
			end
		end
	end

	// Analog indications follow the levels the bench commands
	assign loop_locked_pin = lock_level;
	assign osc_stable_pin = stable_level;
endmodule

// file: verif/clock_generator_mode_control_tb.sv
// Self-checking bench for the clock generator mode control block
`timescale 1ns/1ps
module clock_generator_mode_control_tb;
	import clock_gen_pkg::*;
	localparam int EXT_KHZ = 256;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sys_rst;
	logic osc_req, hg_sel, rng_hi, stop_en, ref_pin, lock_pin, stab_pin, run, lock_lvl, stab_lvl;
	logic [7:0] paddr, trim_value;
	logic [31:0] pwdata, prdata, out_f, bus_f, v;
	scheme_t scheme;
	int fails, n_checks, pulses, p0, i, s;
	logic [7:0] sc_val [3];
	int n_f;

	initial pclk = 1'b0;
	always #10 pclk = ~pclk;

	clock_generator_mode_control #(.EXT_REF_KHZ(EXT_KHZ), .LOSS_TIMEOUT(8)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ref_clock_pin(ref_pin), .loop_locked_pin(lock_pin),
		.osc_stable_pin(stab_pin), .irq(irq), .system_reset_request(sys_rst), .oscillator_request(osc_req),
		.high_gain_select(hg_sel), .range_high(rng_hi), .oscillator_stop_enable(stop_en),
		.clock_scheme_select(scheme), .trim_value(trim_value), .output_freq_khz(out_f), .bus_freq_khz(bus_f));
	ext_clock_source partner (.pclk(pclk), .run(run), .lock_level(lock_lvl), .stable_level(stab_lvl),
		.ref_clock_pin(ref_pin), .loop_locked_pin(lock_pin), .osc_stable_pin(stab_pin));

	// Count one-cycle reset request pulses, since they are gone by the next read
	always @(posedge pclk) begin
		if (sys_rst === 1'b1) begin
			pulses <= pulses + 1;
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic report_and_stop();
		if (fails == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer; everything held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			if (k == 50) begin
				fails++;
				report_and_stop();
			end
			k++;
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {24'h00_0000, d}, r, e);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err_exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		check(r, exp);
		check({31'd0, e}, {31'd0, err_exp});
	endtask

	task automatic rd_flags(output logic [31:0] r);
		logic e;
		apb(1'b0, STATUS_FIRST_ADDR, 32'h0000_0000, r, e);
		r = r & 32'h0000_000E;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{psel, penable, pwrite} = 3'b000;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		presetn = 1'b0;
		{run, lock_lvl, stab_lvl} = 3'b110;
		fails = 0;
		n_checks = 0;
		pulses = 0;
		sc_val = '{8'h00, 8'h10, 8'h58};
		idle(16);
		presetn <= 1'b1;
		// Reset state and register reset values
		idle(2);
		check(out_f, SELF_CLOCKED_KHZ);
		check(bus_f, SELF_CLOCKED_KHZ / 2);
		check(32'(scheme), 32'(SCHEME_SELF));
		rd_chk(SCHEME_CTRL_ADDR, 32'(SCHEME_CTRL_RST), 1'b0);
		rd_chk(FACTOR_CTRL_ADDR, 32'(FACTOR_CTRL_RST), 1'b0);
		rd_chk(TRIM_ADDR, 32'(TRIM_RST), 1'b0);
		rd_chk(IRQ_MASK_ADDR, 32'(IRQ_MASK_RST), 1'b0);
		// Every factor and divider code under self, bypass and engaged external high range
		for (i = 0; i < 8; i++) begin
			wr(FACTOR_CTRL_ADDR, 8'((i << 4) | i));
			for (s = 0; s < 3; s++) begin
				wr(SCHEME_CTRL_ADDR, sc_val[s]);
				idle(3);
				n_f = (s == 0) ? SELF_CLOCKED_KHZ : (s == 1) ? EXT_KHZ : EXT_KHZ * (4 + 2 * i);
				check(out_f, 32'(n_f >> i));
				check(bus_f, 32'((n_f >> i) >> 1));
				check(32'(scheme), 32'(sc_val[s][4:3]));
			end
		end
		check(32'(rng_hi), 32'h0000_0001);
		// Low range engaged external, factor 10
		wr(SCHEME_CTRL_ADDR, 8'h38);
		wr(FACTOR_CTRL_ADDR, 8'h30);
		idle(3);
		check(out_f, 32'(EXT_KHZ * 64 * 10));
		check({30'd0, rng_hi, osc_req}, 32'h0000_0001);
		rd_chk(SCHEME_CTRL_ADDR, 32'h0000_0038, 1'b0);
		// Engaged internal with reference select set, divide by 2
		wr(SCHEME_CTRL_ADDR, 8'h28);
		wr(FACTOR_CTRL_ADDR, 8'h31);
		idle(3);
		check(out_f, 32'((243 * 64 * 10 / 7) >> 1));
		check(32'(osc_req), 32'h0000_0000);
		// Trim with doubled divider, then restore it
		wr(FACTOR_CTRL_ADDR, 8'h32);
		wr(TRIM_ADDR, 8'h5A);
		rd_chk(TRIM_ADDR, 32'h0000_005A, 1'b0);
		check(32'(trim_value), 32'h0000_005A);
		wr(FACTOR_CTRL_ADDR, 8'h31);
		rd_chk(8'h40, 32'h0000_0000, 1'b1);
		// All bits set: bit 0 drops, gain and stop outputs follow
		wr(SCHEME_CTRL_ADDR, 8'hFF);
		rd_chk(SCHEME_CTRL_ADDR, 32'h0000_00FE, 1'b0);
		check({29'd0, hg_sel, rng_hi, stop_en}, 32'h0000_0007);
		wr(SCHEME_CTRL_ADDR, 8'h28);
		idle(2);
		check({31'd0, hg_sel}, 32'h0000_0000);
		// Stable indication is read-only
		stab_lvl <= 1'b1;
		idle(4);
		rd_chk(STATUS_SECOND_ADDR, 32'h0000_0001, 1'b0);
		wr(STATUS_SECOND_ADDR, 8'h00);
		rd_chk(STATUS_SECOND_ADDR, 32'h0000_0001, 1'b0);
		// Lock loss raises a sticky flag; mask gates irq; write-one clears
		wr(IRQ_MASK_ADDR, 8'h06);
		lock_lvl <= 1'b0;
		idle(8);
		rd_flags(v);
		check(v, 32'h0000_0004);
		check({31'd0, irq}, 32'h0000_0001);
		wr(IRQ_MASK_ADDR, 8'h00);
		idle(1);
		check({31'd0, irq}, 32'h0000_0000);
		wr(IRQ_MASK_ADDR, 8'h06);
		wr(STATUS_FIRST_ADDR, 8'h08);
		rd_flags(v);
		check(v, 32'h0000_0004);
		wr(STATUS_FIRST_ADDR, 8'h04);
		rd_flags(v);
		check(v, 32'h0000_0000);
		check({31'd0, irq}, 32'h0000_0000);
		// Lock loss with reset enable gives one reset pulse and no flag
		lock_lvl <= 1'b1;
		idle(6);
		wr(FACTOR_CTRL_ADDR, 8'hB1);
		p0 = pulses;
		lock_lvl <= 1'b0;
		idle(8);
		check(32'(pulses - p0), 32'h0000_0001);
		rd_flags(v);
		check(v, 32'h0000_0000);
		lock_lvl <= 1'b1;
		// Reference clock stops under engaged external
		wr(FACTOR_CTRL_ADDR, 8'h30);
		wr(SCHEME_CTRL_ADDR, 8'h78);
		idle(6);
		run <= 1'b0;
		idle(30);
		rd_flags(v);
		check(v, 32'h0000_000A);
		check({31'd0, irq}, 32'h0000_0001);
		wr(STATUS_FIRST_ADDR, 8'h02);
		run <= 1'b1;
		idle(10);
		wr(FACTOR_CTRL_ADDR, 8'h38);
		p0 = pulses;
		run <= 1'b0;
		idle(30);
		check(32'(pulses - p0), 32'h0000_0001);
		rd_flags(v);
		check(v, 32'h0000_0008);
		report_and_stop();
	end
endmodule
